/* supply_voltage_monitor_control.sv */
// Supply voltage monitor control: registers, filters, flags and reset requests.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module supply_voltage_monitor_control #(
   parameter int EA_CYC = svm_pkg::EA_CYC,
   parameter int REL_CYC = svm_pkg::REL_CYC,
   parameter int OSC_DIV = svm_pkg::OSC_DIV
) (
   // Clock and power-on reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Internal reset of the chip (software, watchdog, monitor), synchronous.
   input wire logic sys_reset,
   // Comparator outputs, high while supply at or above the level.
   input wire logic [2:0] cmp_above,
   // Interrupt requests, one-cycle pulses.
   output logic mon1_irq,
   output logic mon2_irq,
   // Reset requests, levels.
   output logic mon0_reset,
   output logic mon1_reset,
   output logic mon2_reset,
   // Low power detection select.
   output logic low_power_select
);
   // -------------------------------------------------------------
   // Declarations.
   // -------------------------------------------------------------
   localparam int CNT_W_L = svm_pkg::CNT_W;
   logic [7:0] prot_r;
   logic [7:0] vd2_r;
   logic [7:0] mctl_r [3];
   logic [2:0] sync1_r;
   logic [2:0] sync2_r;
   logic [7:0] osc_cnt_r;
   logic osc_tick_r;
   logic [2:0] div_cnt_r [3];
   logic [2:0] samp_en;
   logic [2:0] filt_out;
   logic [2:0] active;
   logic [2:0] lvl;
   logic [2:0] lvl_q_r;
   logic [2:0] evt;
   logic [2:0] men;
   logic [2:1] cross_r;
   logic [2:1] cmpst_r;
   logic [CNT_W_L-1:0] rel_cnt_r;
   svm_pkg::rst2_state_t st_r;
   svm_pkg::rst2_state_t st_nxt;
   logic setup;
   logic wr;
   logic wr_ok;

   // -------------------------------------------------------------
   // Functions.
   // -------------------------------------------------------------
   // True when the address names a register.
   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = (a == svm_pkg::OFS_PROT) || (a == svm_pkg::OFS_VD1) ||
                  (a == svm_pkg::OFS_VD2) || (a == svm_pkg::OFS_MON0) ||
                  (a == svm_pkg::OFS_MON1) || (a == svm_pkg::OFS_MON2);
   endfunction

   // True on the last slow-clock tick of a divide-by-1, 2, 4 or 8 period.
   function automatic logic div_hit(input logic [2:0] c, input logic [1:0] s);
      logic [2:0] m;
      m = 3'h0;
      unique case (s)
         2'h0: m = 3'h0;
         2'h1: m = 3'h1;
         2'h2: m = 3'h3;
         2'h3: m = 3'h7;
      endcase
      div_hit = ((c & m) == m);
   endfunction

   // -------------------------------------------------------------
   // Bus strobes.
   // -------------------------------------------------------------
   // Setup cycle, write taken at the completing access edge, and unlock gate.
   assign setup = psel && !penable;
   assign wr = psel && penable && pready && pwrite;
   assign wr_ok = wr && prot_r[svm_pkg::PROT_UNLOCK];

   // -------------------------------------------------------------
   // Comparator synchronisers and slow clock.
   // -------------------------------------------------------------
   // Two flip-flops per comparator before anything reads it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync1_r <= 3'h7;
         sync2_r <= 3'h7;
      end else begin
         sync1_r <= cmp_above;
         sync2_r <= sync1_r;
      end
   end

   // Slow on-chip oscillator modelled as a one-cycle enable.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_cnt_r <= 8'h00;
         osc_tick_r <= 1'b0;
      end else if (osc_cnt_r == 8'(OSC_DIV - 1)) begin
         osc_cnt_r <= 8'h00;
         osc_tick_r <= 1'b1;
      end else begin
         osc_cnt_r <= osc_cnt_r + 8'h01;
         osc_tick_r <= 1'b0;
      end
   end

   // -------------------------------------------------------------
   // Per-detector filter path.
   // -------------------------------------------------------------
   for (genvar i = 0; i < 3; i++) begin : g_det
      // Divide the slow clock by the selected n.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            div_cnt_r[i] <= 3'h0;
         end else if (osc_tick_r) begin
            div_cnt_r[i] <= div_cnt_r[i] + 3'h1;
         end
      end

      // Sampling enable and chosen level.
      assign samp_en[i] = osc_tick_r &&
         div_hit(div_cnt_r[i], mctl_r[i][svm_pkg::MC_DIV +: 2]);
      assign lvl[i] = mctl_r[i][svm_pkg::MC_FDIS] ? sync2_r[i] : filt_out[i];

      level_filter #(
         .LEN(svm_pkg::FILT_LEN)
      ) u_filt (
         .pclk(pclk),
         .presetn(presetn),
         .sample_en(samp_en[i]),
         .din(sync2_r[i]),
         .dout(filt_out[i])
      );

      enable_delay #(
         .CYC(EA_CYC),
         .W(CNT_W_L)
      ) u_start (
         .pclk(pclk),
         .presetn(presetn),
         .en(vd2_r[svm_pkg::VD2_DET0 + i]),
         .active(active[i])
      );

      // Crossing events; filter off narrows them to one direction.
      assign evt[i] = active[i] && (lvl[i] != lvl_q_r[i]) &&
         (!mctl_r[i][svm_pkg::MC_FDIS] ||
          (mctl_r[i][svm_pkg::MC_TRIG] ? !lvl[i] : lvl[i]));

      // Monitor enable only counts while its detector runs.
      assign men[i] = mctl_r[i][svm_pkg::MC_EN] && active[i];

      // Previous level for edge detection, parked high while inactive.
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            lvl_q_r[i] <= 1'b1;
         end else if (!active[i]) begin
            lvl_q_r[i] <= 1'b1;
         end else begin
            lvl_q_r[i] <= lvl[i];
         end
      end
   end

   // -------------------------------------------------------------
   // Registers.
   // -------------------------------------------------------------
   // Protect register; cleared by any internal reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prot_r <= svm_pkg::PROT_RST;
      end else if (sys_reset) begin
         prot_r <= svm_pkg::PROT_RST;
      end else if (wr && paddr == svm_pkg::OFS_PROT) begin
         prot_r <= pwdata[7:0];
      end
   end

   // Detector enables; kept through internal resets.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         vd2_r <= svm_pkg::VD2_RST;
      end else if (wr_ok && paddr == svm_pkg::OFS_VD2) begin
         vd2_r <= pwdata[7:0];
      end
   end

   // Monitor controls; zero kept, one and two cleared by internal reset.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int k = 0; k < 3; k++) begin
            mctl_r[k] <= svm_pkg::MCTL_RST;
         end
      end else if (sys_reset) begin
         mctl_r[1] <= svm_pkg::MCTL_RST;
         mctl_r[2] <= svm_pkg::MCTL_RST;
      end else if (wr_ok) begin
         for (int k = 0; k < 3; k++) begin
            if (paddr == svm_pkg::OFS_MON0 + 8'(4 * k)) begin
               mctl_r[k] <= pwdata[7:0] & 8'hf3;
            end
         end
      end
   end

   // Sticky crossing flags and compare flags; no internal reset clears them.
   for (genvar j = 1; j < 3; j++) begin : g_flag
      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cross_r[j] <= 1'b0;
         end else if (evt[j]) begin
            cross_r[j] <= 1'b1;
         end else if (wr_ok && paddr == svm_pkg::OFS_MON0 + 8'(4 * j) &&
                      !pwdata[svm_pkg::MC_CROSS]) begin
            cross_r[j] <= 1'b0;
         end
      end

      always_ff @(posedge pclk or negedge presetn) begin
         if (!presetn) begin
            cmpst_r[j] <= 1'b1;
         end else if (active[j]) begin
            cmpst_r[j] <= lvl[j];
         end
      end
   end

   // -------------------------------------------------------------
   // APB answer.
   // -------------------------------------------------------------
   // Zero-wait answer: data and ready are registered in the setup cycle.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= setup;
         pslverr <= setup && !is_mapped(paddr);
      end
   end

   // Read data mux.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
      end else if (setup && !pwrite) begin
         prdata <= 32'h0000_0000;
         unique case (paddr)
            svm_pkg::OFS_PROT: prdata[7:0] <= prot_r;
            svm_pkg::OFS_VD1:
               prdata[svm_pkg::VD1_L2STAT] <= active[2] ? lvl[2] : 1'b1;
            svm_pkg::OFS_VD2: prdata[7:0] <= vd2_r;
            svm_pkg::OFS_MON0: prdata[7:0] <= mctl_r[0];
            svm_pkg::OFS_MON1: prdata[7:0] <= mctl_r[1] |
               {4'h0, cmpst_r[1], cross_r[1], 2'h0};
            svm_pkg::OFS_MON2: prdata[7:0] <= mctl_r[2] |
               {4'h0, cmpst_r[2], cross_r[2], 2'h0};
            default: prdata <= 32'h0000_0000;
         endcase
      end
   end

   // -------------------------------------------------------------
   // Interrupt and reset requests.
   // -------------------------------------------------------------
   // Interrupt pulses in interrupt mode; mode bit only counts when enabled.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon1_irq <= 1'b0;
         mon2_irq <= 1'b0;
      end else begin
         mon1_irq <= men[1] && !mctl_r[1][svm_pkg::MC_MODE] && evt[1];
         mon2_irq <= men[2] && !mctl_r[2][svm_pkg::MC_MODE] && evt[2];
      end
   end

   // Level resets for monitors zero and one follow the supply directly.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mon0_reset <= 1'b0;
         mon1_reset <= 1'b0;
      end else begin
         mon0_reset <= men[0] && mctl_r[0][svm_pkg::MC_MODE] && !lvl[0];
         mon1_reset <= men[1] && mctl_r[1][svm_pkg::MC_MODE] && !lvl[1];
      end
   end

   // Level-two reset sequencer next state.
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         svm_pkg::R2_IDLE:
            if (men[2] && mctl_r[2][svm_pkg::MC_MODE] && !lvl[2]) begin
               st_nxt = svm_pkg::R2_HOLD;
            end
         svm_pkg::R2_HOLD:
            if (lvl[2]) begin
               st_nxt = svm_pkg::R2_WAIT;
            end
         svm_pkg::R2_WAIT:
            if (!lvl[2]) begin
               st_nxt = svm_pkg::R2_HOLD;
            end else if (rel_cnt_r == CNT_W_L'(REL_CYC - 1)) begin
               st_nxt = svm_pkg::R2_IDLE;
            end
         default: st_nxt = svm_pkg::R2_IDLE;
      endcase
   end

   // Level-two sequencer state and its own reset output.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r <= svm_pkg::R2_IDLE;
         mon2_reset <= 1'b0;
      end else begin
         st_r <= st_nxt;
         mon2_reset <= (st_nxt != svm_pkg::R2_IDLE);
      end
   end

   // Release delay counter, running only while waiting.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rel_cnt_r <= '0;
      end else if (st_r != svm_pkg::R2_WAIT) begin
         rel_cnt_r <= '0;
      end else begin
         rel_cnt_r <= rel_cnt_r + CNT_W_L'(1);
      end
   end

   // Low power select is a registered copy of its register bit, one cycle behind it.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         low_power_select <= 1'b0;
      end else begin
         low_power_select <= vd2_r[svm_pkg::VD2_LOWPWR];
      end
   end
endmodule // supply_voltage_monitor_control
`default_nettype wire

/* svm_pkg.sv */
// Constants, register map and types of the supply voltage monitor control block.
// Contract
// - A detector enabled from zero waits the start-up delay before results count.
// - Level-two compare status reads one while detector two is disabled.
// - Level-two compare status follows the supply against level two while detector two runs.
// - Voltage detect register one survives all internal resets.
// - Monitor zero control survives all internal resets.
// - Monitor zero enable acts only while detector zero is enabled.
// - Monitor zero trigger timing acts only with its filter disabled.
// - Level-one flag and status operate only while detector one is enabled.
// - Level-one crossing flag is sticky; writing zero clears, one is ignored.
// - Level-one mode select acts only while monitor one is enabled.
// - Level-one flag and status survive all internal resets.
// - Monitor two enable acts only while detector two is enabled.
// - Level-two mode select acts only while monitor two is enabled.
// - Level-two trigger timing acts only with its filter disabled.
// - Level-two crossing and compare flags survive all internal resets.
// - Filter on: request both directions; filter off: only the selected one.
// - Filters sample slow clock divided by 1, 2, 4 or 8, accept after 4.
// - Level-two reset holds while low, releases after a fixed delay.
// - Level-one reset holds while low, releases as soon as supply recovers.
package svm_pkg;
   // -------------------------------------------------------------
   // Register offsets.
   // -------------------------------------------------------------
   localparam logic [7:0] OFS_PROT = 8'h00;
   localparam logic [7:0] OFS_VD1 = 8'h04;
   localparam logic [7:0] OFS_VD2 = 8'h08;
   localparam logic [7:0] OFS_MON0 = 8'h0c;
   localparam logic [7:0] OFS_MON1 = 8'h10;
   localparam logic [7:0] OFS_MON2 = 8'h14;
   // -------------------------------------------------------------
   // Field positions.
   // -------------------------------------------------------------
   localparam int PROT_UNLOCK = 3;
   localparam int VD1_L2STAT = 3;
   localparam int VD2_LOWPWR = 3;
   localparam int VD2_DET0 = 5;
   localparam int MC_EN = 0;
   localparam int MC_FDIS = 1;
   localparam int MC_CROSS = 2;
   localparam int MC_CMP = 3;
   localparam int MC_DIV = 4;
   localparam int MC_MODE = 6;
   localparam int MC_TRIG = 7;
   // -------------------------------------------------------------
   // Reset values.
   // -------------------------------------------------------------
   localparam logic [7:0] PROT_RST = 8'h00;
   localparam logic [7:0] VD2_RST = 8'h00;
   localparam logic [7:0] MCTL_RST = 8'h00;
   // -------------------------------------------------------------
   // Timing.
   // -------------------------------------------------------------
   localparam int CLK_HZ = 20_000_000;
   localparam int OSC_HZ = 125_000;
   localparam int OSC_DIV = CLK_HZ / OSC_HZ;
   localparam int FILT_LEN = 4;
   localparam int T_EA_US = 100;
   localparam int EA_CYC = (T_EA_US * (CLK_HZ / 1_000_000));
   localparam int T_REL_US = 200;
   localparam int REL_CYC = (T_REL_US * (CLK_HZ / 1_000_000));
   localparam int CNT_W = 12;
   // Level-two reset sequencer states.
   typedef enum logic [1:0] {
      R2_IDLE = 2'b00,
      R2_HOLD = 2'b01,
      R2_WAIT = 2'b11
   } rst2_state_t;
endpackage

/* level_filter.sv */
// Digital noise filter that accepts a level after a run of equal samples.
`timescale 1ns/1ps
`default_nettype none
module level_filter #(
   parameter int LEN = 4
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Samples.
   input wire logic sample_en,
   input wire logic din,
   // Accepted level.
   output logic dout
);
   logic [LEN-1:0] hist_r;
   logic [LEN-1:0] win;

   // Window of the newest samples, including the one arriving now.
   assign win = {hist_r[LEN-2:0], din};

   // Shift in one sample per sampling period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hist_r <= '1;
      end else if (sample_en) begin
         hist_r <= win;
      end
   end

   // Change the output only once all samples in the window agree.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dout <= 1'b1;
      end else if (sample_en && (&win)) begin
         dout <= 1'b1;
      end else if (sample_en && !(|win)) begin
         dout <= 1'b0;
      end
   end
endmodule // level_filter
`default_nettype wire

/* enable_delay.sv */
// Start-up wait that marks a detector active a fixed time after its enable rises.
`timescale 1ns/1ps
`default_nettype none
module enable_delay #(
   parameter int CYC = 2000,
   parameter int W = 12
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Enable and result.
   input wire logic en,
   output logic active
);
   logic [W-1:0] cnt_r;

   // Count from the rising enable; dropping the enable restarts the wait.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r <= '0;
         active <= 1'b0;
      end else if (!en) begin
         cnt_r <= '0;
         active <= 1'b0;
      end else if (cnt_r == W'(CYC - 1)) begin
         active <= 1'b1;
      end else begin
         cnt_r <= cnt_r + W'(1);
      end
   end
endmodule // enable_delay
`default_nettype wire

/* svm_assertions.sv */
// Concurrent checks on the ports of the supply voltage monitor control block.
`timescale 1ns/1ps
`default_nettype none
module svm_assertions #(
   parameter int REL_CYC = 4000
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Register bus.
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   // Monitor side.
   input wire logic [2:0] cmp_above,
   input wire logic mon1_irq,
   input wire logic mon2_irq,
   input wire logic mon2_reset
);
   // ---------------------------------------------------------------
   // Helper logic.
   // ---------------------------------------------------------------
   logic mapped;
   logic setup;

   // Decodes whether the presented address hits one of the six registers.
   assign mapped = paddr inside {svm_pkg::OFS_PROT, svm_pkg::OFS_VD1, svm_pkg::OFS_VD2,
      svm_pkg::OFS_MON0, svm_pkg::OFS_MON1, svm_pkg::OFS_MON2};
   assign setup = psel && !penable;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // ---------------------------------------------------------------
   // Assertions.
   // ---------------------------------------------------------------
   a_ready_after_setup: assert property (setup |=> pready)
      else $error("pready missing after setup cycle");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   a_err_with_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_err_unmapped: assert property (setup && !mapped |=> pslverr)
      else $error("unmapped access not flagged");
   a_no_err_mapped: assert property (setup && mapped |=> !pslverr)
      else $error("mapped access flagged as error");
   a_upper_read_zero: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("upper read data bits not zero");
   a_irq1_single_pulse: assert property (mon1_irq |=> !mon1_irq)
      else $error("level one request longer than one cycle");
   a_irq2_single_pulse: assert property (mon2_irq |=> !mon2_irq)
      else $error("level two request longer than one cycle");
   a_l2_release_wait: assert property ($fell(mon2_reset) |->
      $past(cmp_above[2], 3) && $past(cmp_above[2], 8))
      else $error("level two reset released without recovery delay");

   // Main scenarios seen.
   c_irq1: cover property (mon1_irq);
   c_irq2: cover property (mon2_irq);
   c_unmapped: cover property (pslverr);
   c_l2_release: cover property ($fell(mon2_reset));
endmodule // svm_assertions
`default_nettype wire

/* tb.sv */
// Self-checking testbench for the supply voltage monitor control block.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic pclk, presetn, psel, penable, pwrite, sys_reset, pready, pslverr, er;
   logic [7:0] paddr, d;
   logic [31:0] pwdata, prdata;
   logic [2:0] cmp_above;
   logic mon1_irq, mon2_irq, mon0_reset, mon1_reset, mon2_reset, low_power_select;
   int num_errors, check_count, irq1_n, irq2_n, b;

   supply_voltage_monitor_control #(.EA_CYC(8), .REL_CYC(8), .OSC_DIV(2))
      supply_voltage_monitor_control_i (.pclk(pclk), .presetn(presetn), .paddr(paddr),
      .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sys_reset(sys_reset), .cmp_above(cmp_above),
      .mon1_irq(mon1_irq), .mon2_irq(mon2_irq), .mon0_reset(mon0_reset),
      .mon1_reset(mon1_reset), .mon2_reset(mon2_reset), .low_power_select(low_power_select));

   // Clock at 20 MHz.
   always #25 pclk = ~pclk;

   // Counts request pulses of both monitors.
   always @(posedge pclk) begin
      if (mon1_irq === 1'b1) irq1_n++;
      if (mon2_irq === 1'b1) irq2_n++;
   end

   // ---------------------------------------------------------------
   // Tasks.
   // ---------------------------------------------------------------
   task automatic end_sim;
      if (num_errors == 0 && check_count > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      check_count++;
      if (got !== exp) begin
         num_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; waits for pready, and only the watchdog ends a hang.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      d = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] wd);
      apb(1'b1, a, wd);
   endtask

   task automatic rdm(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      apb(1'b0, a, 8'h00);
      chk(d & m, e);
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic setc(input int i, input logic v);
      @(posedge pclk);
      cmp_above[i] <= v;
   endtask

   // Cuts a hang short.
   initial begin
      repeat (5000) @(posedge pclk);
      num_errors++;
      end_sim();
   end

   // ---------------------------------------------------------------
   // Main sequence.
   // ---------------------------------------------------------------
   initial begin
      pclk = 1'b0;
      presetn = 1'b0;
      {psel, penable, pwrite, sys_reset} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      cmp_above = 3'b111;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      rdm(svm_pkg::OFS_VD2, 8'hff, svm_pkg::VD2_RST);
      wr(svm_pkg::OFS_MON0, 8'h02);
      rdm(svm_pkg::OFS_MON0, 8'hf3, 8'h00);
      wr(svm_pkg::OFS_PROT, 8'h08);
      wr(svm_pkg::OFS_MON0, 8'h02);
      rdm(svm_pkg::OFS_MON0, 8'hf3, 8'h02);
      apb(1'b0, 8'h18, 8'h00);
      chk({7'h0, er}, 8'h01);
      setc(2, 1'b0);
      rdm(svm_pkg::OFS_VD1, 8'h08, 8'h08);
      wr(svm_pkg::OFS_VD2, 8'he8);
      cyc(2);
      chk({7'h0, low_power_select}, 8'h01);
      rdm(svm_pkg::OFS_VD1, 8'h08, 8'h08);
      cyc(12);
      rdm(svm_pkg::OFS_VD1, 8'h08, 8'h00);
      setc(2, 1'b1);
      cyc(12);
      rdm(svm_pkg::OFS_VD1, 8'h08, 8'h08);
      // Level one, filter off, falling edge only.
      wr(svm_pkg::OFS_MON1, 8'h83);
      b = irq1_n;
      setc(1, 1'b0);
      cyc(6);
      chk(8'(irq1_n - b), 8'h01);
      rdm(svm_pkg::OFS_MON1, 8'h0c, 8'h04);
      setc(1, 1'b1);
      cyc(6);
      chk(8'(irq1_n - b), 8'h01);
      wr(svm_pkg::OFS_MON1, 8'h87);
      rdm(svm_pkg::OFS_MON1, 8'h0c, 8'h0c);
      wr(svm_pkg::OFS_MON1, 8'h83);
      rdm(svm_pkg::OFS_MON1, 8'h0c, 8'h08);
      setc(1, 1'b0);
      cyc(6);
      setc(1, 1'b1);
      cyc(6);
      // Level two, filter on with n of 1 and then 8.
      wr(svm_pkg::OFS_MON2, 8'h01);
      b = irq2_n;
      setc(2, 1'b0);
      cyc(30);
      setc(2, 1'b1);
      cyc(30);
      chk(8'(irq2_n - b), 8'h02);
      wr(svm_pkg::OFS_MON2, 8'h31);
      b = irq2_n;
      setc(2, 1'b0);
      cyc(40);
      chk(8'(irq2_n - b), 8'h00);
      cyc(60);
      chk(8'(irq2_n - b), 8'h01);
      // Internal reset keeps flags and the monitor zero setting.
      @(posedge pclk);
      sys_reset <= 1'b1;
      @(posedge pclk);
      sys_reset <= 1'b0;
      cyc(2);
      rdm(svm_pkg::OFS_VD1, 8'h08, 8'h00);
      rdm(svm_pkg::OFS_MON0, 8'hf3, 8'h02);
      rdm(svm_pkg::OFS_MON1, 8'h0c, 8'h0c);
      rdm(svm_pkg::OFS_MON2, 8'h0c, 8'h04);
      wr(svm_pkg::OFS_MON0, 8'h00);
      rdm(svm_pkg::OFS_MON0, 8'hf3, 8'h02);
      // Reset modes of all three monitors.
      wr(svm_pkg::OFS_PROT, 8'h08);
      setc(2, 1'b1);
      wr(svm_pkg::OFS_MON1, 8'hc2);
      setc(1, 1'b0);
      cyc(6);
      chk({7'h0, mon1_reset}, 8'h00);
      wr(svm_pkg::OFS_MON1, 8'hc3);
      cyc(4);
      chk({7'h0, mon1_reset}, 8'h01);
      setc(1, 1'b1);
      cyc(6);
      chk({7'h0, mon1_reset}, 8'h00);
      // Monitor zero reset follows the level while enabled in reset mode.
      wr(svm_pkg::OFS_MON0, 8'hc2);
      setc(0, 1'b0);
      cyc(6);
      chk({7'h0, mon0_reset}, 8'h00);
      wr(svm_pkg::OFS_MON0, 8'hc3);
      cyc(4);
      chk({7'h0, mon0_reset}, 8'h01);
      setc(0, 1'b1);
      cyc(6);
      chk({7'h0, mon0_reset}, 8'h00);
      wr(svm_pkg::OFS_MON2, 8'hc2);
      setc(2, 1'b0);
      cyc(6);
      chk({7'h0, mon2_reset}, 8'h00);
      setc(2, 1'b1);
      cyc(6);
      wr(svm_pkg::OFS_MON2, 8'hc3);
      setc(2, 1'b0);
      cyc(6);
      chk({7'h0, mon2_reset}, 8'h01);
      setc(2, 1'b1);
      cyc(5);
      chk({7'h0, mon2_reset}, 8'h01);
      cyc(15);
      chk({7'h0, mon2_reset}, 8'h00);
      end_sim();
   end
endmodule // tb

bind supply_voltage_monitor_control svm_assertions #(.REL_CYC(REL_CYC)) svm_assertions_i (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .cmp_above(cmp_above),
   .mon1_irq(mon1_irq), .mon2_irq(mon2_irq), .mon2_reset(mon2_reset));
`default_nettype wire
